/* flyback_model.sv */
/*
 Behavioural flyback stage: winding voltage and current simulation as seen
 by the comparators, answering the gate drive.
 Assumes the gate comes from a flop on the same rising clock edge.
*/
`timescale 1ns/1ns
module flyback_model #(
	parameter int ON_CYC = 40,
	parameter int DEMAG = 100,
	parameter int HALF = 20
) (
	// Clock
	input wire logic clk,
	// Gate drive and chosen behaviour
	input wire logic gate,
	input wire logic [1:0] mode,
	// Comparator levels
	output logic below_low,
	output logic above_1v,
	output logic sim_fb
);
	int t; // Cycles since the gate last changed
	int u; // Same, zero in the cycle of a change
	logic last; // Gate one cycle ago
	logic hi; // Winding above the low threshold

	initial begin
		t = 0;
		last = 1'h0;
	end

	// Time since the last gate edge
	always @(posedge clk) begin
		t <= (gate != last) ? 0 : t + 1;
		last <= gate;
	end

	// Mode 0 rings eight times, 1 and 3 damp at once, 2 stays high
	always_comb begin
		u = (gate != last) ? 0 : t;
		if (gate)
			hi = u >= ON_CYC;
		else if (mode == 2'h2 || u < DEMAG)
			hi = 1'h1;
		else if (mode[0] || u >= DEMAG + 16 * HALF)
			hi = 1'h0;
		else
			hi = ((u - DEMAG) / HALF) % 2 == 1;
		below_low = !hi;
		// Mode 3 turns off below one volt
		above_1v = hi && mode != 2'h3;
		sim_fb = gate && u >= ON_CYC;
	end
endmodule

/* period_tick.sv */
/*
 Periodic one-cycle tick from a cycle counter with a hold input.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module period_tick #(
	parameter int W = 20,
	parameter logic [W-1:0] LAST = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Restart the period while high
	input wire logic hold,
	// One-cycle pulse at the end of each period
	output logic tick
);
	// Whole state of the divider
	typedef struct packed {
		logic [W-1:0] count;
		logic tick;
	} tick_s;

	tick_s st; // Current state
	tick_s next_st; // Next state

	// Count up, wrap and pulse
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (hold) begin
			next_st.count = '0;
		end else if (st.count == LAST) begin
			next_st.count = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.count = st.count + 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
endmodule

/* qr_gate_cfg.svh */
/*
 Constants of the quasi-resonant gate control: timing figures in their own
 units with derived cycle counts, counter limits and register map.
 Assumes a 20 MHz system clock; all counts are derived from CLK_MHZ.
*/
`ifndef QR_GATE_CFG_SVH
`define QR_GATE_CFG_SVH

// System clock rate
`define CLK_MHZ 20

// Least times in nanoseconds, rounded up to whole cycles
`define RING_SHORT_NS 3000
`define RING_LONG_NS 30000
`define BURST_ARM_NS 12000
`define RESTART_NS 50000
`define NS_TO_CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define RING_SHORT_CYC `NS_TO_CYC(`RING_SHORT_NS)
`define RING_LONG_CYC `NS_TO_CYC(`RING_LONG_NS)
`define BURST_ARM_CYC `NS_TO_CYC(`BURST_ARM_NS)
`define RESTART_CYC `NS_TO_CYC(`RESTART_NS)

// Skip counter step period in milliseconds
`define STEP_MS 50
`define STEP_CYC (`STEP_MS * 1000 * 1000 * `CLK_MHZ / 1000)

// Skip counter values
`define SKIP_RESET 4'h1
`define SKIP_JUMP 4'h1
`define SKIP_FLOOR 4'h1
`define SKIP_CEIL 4'hf

// Register map
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define CTRL_RUN_BIT 0
`define CTRL_RUN_RESET 1'b1
`define ST_SKIP_LSB 0
`define ST_ZC_LSB 4
`define ST_GATE_BIT 8
`define ST_OV_BIT 9
`define ST_FAULT_BIT 10
`define ST_MAINS_BIT 11
`define ST_BURST_BIT 12
`define ST_MODE_LSB 13
`define ST_RING_BIT 15

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* qr_gate_control.sv */
/*
 Switching logic of a quasi-resonant flyback controller: valley counting,
 skip counter, ringing suppression, restart, burst mode, protection latches
 and an AXI4-Lite register slave.
 Assumes all comparator flags are synchronous to CLOCK.
*/
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
// Behaviour
// - Count each falling crossing below low threshold
// - Turn gate on when crossings equal skip
// - Hold gate low while above low threshold
// - Current reaching feedback ends pulse, starts suppression
// - Suppression short above 1V, ten times longer below
// - Discharge sink follows primary regulation comparator
// - Intermediate flag disconnects charging resistor at restart
// - Gate falling edge reconnects charging resistor
// - Four-bit skip counter of ignored crossings
// - Low feedback increments skip each step
// - High feedback decrements, middle range holds
// - Load jump sets skip to one immediately
// - Range flags acted on only at step tick
// - Range flags cleared after each step tick
// - Burst comparator armed after soft-start delay
// - Burst forces gate low, raises turn-off threshold
// - Burst turn-off restarts, turn-on restores threshold
// - Restart pulse turns gate on when idle
// - Restart suppressed above restart threshold
// - Overvoltage latch disables gate until supply drops
// - Fault latch disables gate, same clearing
// - Mains undervoltage latches gate low
`timescale 1ns/1ns
`include "qr_gate_cfg.svh"
module qr_gate_control #(
	parameter int STEP_CYCLES = `STEP_CYC
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// Register bus
	input wire qr_gate_pkg::axi_req_s AXI_IN,
	output qr_gate_pkg::axi_rsp_s AXI_OUT,
	// Comparators and power stage
	input wire qr_gate_pkg::sense_s SENSE,
	output qr_gate_pkg::drive_s DRIVE
);
	import qr_gate_pkg::*;

	// Whole state of the block
	typedef struct packed {
		mode_e mode; // Start-up, soft start or run
		logic [9:0] arm_cnt; // Burst arming delay
		logic [9:0] ring_cnt; // Ringing suppression left
		logic [3:0] skip; // Crossings to skip
		logic [3:0] zc_cnt; // Crossings this off-period
		logic zc_low_d; // Previous low-threshold flag
		logic gate; // Gate drive
		logic sink; // Discharge sink enable
		logic res_on; // Charging resistor connected
		logic inter_flag; // Intermediate threshold seen
		logic burst; // Burst mode active
		logic ov; // Overvoltage latch
		logic fault; // Fault comparator latch
		logic mains; // Mains undervoltage latch
		logic range_low; // Feedback below lower limit seen
		logic range_high; // Feedback above upper limit seen
		logic ctrl_run; // Software gate enable
		logic aw_held; // Write address captured
		logic [7:0] aw_addr; // Captured write address
		logic w_held; // Write data captured
		logic [31:0] w_data; // Captured write data
		logic [3:0] w_strb; // Captured byte enables
		axi_rsp_s axi; // Bus answer flops
	} state_s;

	localparam logic [9:0] RING_SHORT = 10'(`RING_SHORT_CYC);
	localparam logic [9:0] RING_LONG = 10'(`RING_LONG_CYC);
	localparam logic [9:0] ARM_LAST = 10'(`BURST_ARM_CYC - 1);

	state_s st; // Current state
	state_s next_st; // Next state
	logic step_tick; // Skip counter step
	logic restart_tick; // Restart pulse
	logic restart_hold; // Restart timer held
	logic crossing; // Falling crossing this cycle
	logic blocked; // Any reason keeping gate low, ringing suppression aside
	logic ring_active; // Suppression running
	logic operating; // Reference is on
	logic low_seen; // Lower range at step
	logic high_seen; // Upper range at step
	logic [3:0] zc_inc; // Count after this crossing

	// Saturating increment of a 4-bit count
	function automatic logic [3:0] sat_inc(input logic [3:0] v);
		sat_inc = (v == `SKIP_CEIL) ? v : v + 4'h1;
	endfunction

	// Status word assembled from the state
	function automatic logic [31:0] status_word(input state_s s);
		logic [31:0] w;
		w = 32'h00000000;
		w[`ST_SKIP_LSB +: 4] = s.skip;
		w[`ST_ZC_LSB +: 4] = s.zc_cnt;
		w[`ST_GATE_BIT] = s.gate;
		w[`ST_OV_BIT] = s.ov;
		w[`ST_FAULT_BIT] = s.fault;
		w[`ST_MAINS_BIT] = s.mains;
		w[`ST_BURST_BIT] = s.burst;
		w[`ST_MODE_LSB +: 2] = s.mode;
		w[`ST_RING_BIT] = (s.ring_cnt != 10'h000);
		status_word = w;
	endfunction

	// Step period divider
	period_tick #(
		.W(20),
		.LAST(20'(STEP_CYCLES - 1))
	) step_div (
		.clk(CLOCK),
		.rst_b(RST_B),
		.hold(1'b0),
		.tick(step_tick)
	);

	// Restart timer runs only while idle below the restart threshold
	assign restart_hold = !(SENSE.zc_below_restart && !st.gate);
	period_tick #(
		.W(10),
		.LAST(10'(`RESTART_CYC - 1))
	) restart_div (
		.clk(CLOCK),
		.rst_b(RST_B),
		.hold(restart_hold),
		.tick(restart_tick)
	);

	// Decoded conditions
	always_comb begin
		crossing = SENSE.zc_below_low && !st.zc_low_d;
		zc_inc = sat_inc(st.zc_cnt);
		ring_active = (st.ring_cnt != 10'h000);
		operating = (st.mode != MODE_STARTUP);
		// Any of these keeps the gate low
		blocked = !SENSE.zc_below_low
			|| st.ov
			|| st.fault
			|| st.mains
			|| st.burst
			|| !operating
			|| !st.ctrl_run;
		low_seen = st.range_low || SENSE.fb_below_lower;
		high_seen = st.range_high || SENSE.fb_above_upper;
	end

	// Switching, counters, modes and bus
	always_comb begin
		next_st = st;
		next_st.zc_low_d = SENSE.zc_below_low;
		next_st.sink = SENSE.zc_above_primreg;
		// Crossing counter
		if (crossing) begin
			next_st.zc_cnt = zc_inc;
		end
		// Suppression countdown
		if (ring_active) begin
			next_st.ring_cnt = st.ring_cnt - 10'h001;
		end
		// Gate control
		if (st.gate) begin
			if (SENSE.sim_reached_fb) begin
				next_st.gate = 1'b0;
				// Length picked from the ringing level
				next_st.ring_cnt = SENSE.zc_above_1v ? RING_SHORT : RING_LONG;
			end else if (blocked) begin
				next_st.gate = 1'b0;
			end
			if (!next_st.gate) begin
				next_st.zc_cnt = 4'h0;
			end
		end else if (!blocked && !ring_active) begin
			// Valley match or idle restart
			if (crossing && zc_inc == st.skip) begin
				next_st.gate = 1'b1;
			end else if (restart_tick) begin
				next_st.gate = 1'b1;
			end
		end
		// Charging resistor: set wins over the clear of the flag
		next_st.inter_flag = SENSE.zc_above_inter
			|| (st.inter_flag && !SENSE.zc_below_restart);
		if (st.inter_flag && SENSE.zc_below_restart) begin
			next_st.res_on = 1'b0;
		end
		if (st.gate && !next_st.gate) begin
			next_st.res_on = 1'b1;
		end
		// Skip counter, held between ticks except on a load jump
		if (SENSE.fb_above_jump) begin
			next_st.skip = `SKIP_JUMP;
		end else if (step_tick) begin
			if (low_seen && !high_seen) begin
				next_st.skip = sat_inc(st.skip);
			end else if (high_seen && !low_seen && st.skip != `SKIP_FLOOR) begin
				next_st.skip = st.skip - 4'h1;
			end
		end
		// Range flags: the tick consumes what arrived in its own cycle
		if (step_tick) begin
			next_st.range_low = 1'b0;
			next_st.range_high = 1'b0;
		end else begin
			next_st.range_low = st.range_low || SENSE.fb_below_lower;
			next_st.range_high = st.range_high || SENSE.fb_above_upper;
		end
		// Protection latches, set wins over clear
		next_st.ov = SENSE.supply_above_ov
			|| (st.ov && !SENSE.supply_below_ov_clear);
		next_st.fault = SENSE.fault_above
			|| (st.fault && !SENSE.supply_below_ov_clear);
		next_st.mains = (!st.gate && SENSE.mains_low)
			|| (st.mains && operating);
		// Operating mode
		unique case (st.mode)
			MODE_STARTUP: begin
				if (SENSE.supply_above_on) begin
					next_st.mode = MODE_SOFT;
					next_st.arm_cnt = 10'h000;
					next_st.burst = 1'b0;
				end
			end
			MODE_SOFT: begin
				// Burst comparator ignored until armed
				if (st.arm_cnt == ARM_LAST) begin
					next_st.mode = MODE_RUN;
				end else begin
					next_st.arm_cnt = st.arm_cnt + 10'h001;
				end
			end
			MODE_RUN: begin
				if (SENSE.fb_below_burst) begin
					next_st.burst = 1'b1;
				end
			end
		endcase
		// Supply turn-off at the active threshold
		if (operating) begin
			if (st.burst ? SENSE.supply_below_off_burst : SENSE.supply_below_off) begin
				next_st.mode = MODE_STARTUP;
			end
		end
		// Bus write channels
		if (AXI_IN.awvalid && st.axi.awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = AXI_IN.awaddr;
		end
		if (AXI_IN.wvalid && st.axi.wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = AXI_IN.wdata;
			next_st.w_strb = AXI_IN.wstrb;
		end
		// Write performed once both halves are held
		if (st.aw_held && st.w_held && !st.axi.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.axi.bvalid = 1'b1;
			next_st.axi.bresp = `RESP_OKAY;
			if (st.aw_addr == `CTRL_OFS) begin
				if (st.w_strb[0]) begin
					next_st.ctrl_run = st.w_data[`CTRL_RUN_BIT];
				end
			end else if (st.aw_addr != `STATUS_OFS) begin
				next_st.axi.bresp = `RESP_SLVERR;
			end
		end else if (st.axi.bvalid && AXI_IN.bready) begin
			next_st.axi.bvalid = 1'b0;
		end
		next_st.axi.awready = !next_st.aw_held && !next_st.axi.bvalid;
		next_st.axi.wready = !next_st.w_held && !next_st.axi.bvalid;
		// Bus read channel
		if (AXI_IN.arvalid && st.axi.arready) begin
			next_st.axi.rvalid = 1'b1;
			next_st.axi.rresp = `RESP_OKAY;
			if (AXI_IN.araddr == `CTRL_OFS) begin
				next_st.axi.rdata = {31'h00000000, st.ctrl_run};
			end else if (AXI_IN.araddr == `STATUS_OFS) begin
				next_st.axi.rdata = status_word(st);
			end else begin
				next_st.axi.rdata = 32'h00000000;
				next_st.axi.rresp = `RESP_SLVERR;
			end
		end else if (st.axi.rvalid && AXI_IN.rready) begin
			next_st.axi.rvalid = 1'b0;
		end
		next_st.axi.arready = !next_st.axi.rvalid;
	end

	// State register with defined reset values
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			st <= '0;
			st.skip <= `SKIP_RESET;
			st.res_on <= 1'b1;
			st.ctrl_run <= `CTRL_RUN_RESET;
			st.axi.awready <= 1'b1;
			st.axi.wready <= 1'b1;
			st.axi.arready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flops
	assign AXI_OUT = st.axi;
	assign DRIVE = '{gate: st.gate, discharge_sink: st.sink,
		charge_res_on: st.res_on, burst_threshold: st.burst};

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	// Soft start entry followed by the unarmed stretch
	sequence soft_entry;
		st.mode == MODE_STARTUP ##1 st.mode == MODE_SOFT;
	endsequence

	sequence unarmed_stretch;
		(st.mode == MODE_SOFT && !st.burst) [*8];
	endsequence

	zc_low_hold_a: assert property (!SENSE.zc_below_low |=> !st.gate)
		else $error("gate high while above low threshold");
	ring_load_a: assert property (st.gate && SENSE.sim_reached_fb |=> !st.gate
		&& st.ring_cnt == ($past(SENSE.zc_above_1v) ? RING_SHORT : RING_LONG))
		else $error("suppression not loaded with correct length");
	ring_block_a: assert property (st.ring_cnt != 10'h000 |=> !$rose(st.gate))
		else $error("gate rose during suppression");
	zc_count_a: assert property (crossing && !st.gate && st.zc_cnt != 4'hf
		|=> st.zc_cnt == $past(st.zc_cnt) + 4'h1)
		else $error("crossing not counted");
	skip_jump_a: assert property (SENSE.fb_above_jump |=> st.skip == `SKIP_JUMP)
		else $error("skip not set on load jump");
	skip_stable_a: assert property (!step_tick && !SENSE.fb_above_jump
		|=> $stable(st.skip))
		else $error("skip changed between ticks");
	range_clear_a: assert property (step_tick |=> !st.range_low && !st.range_high)
		else $error("range flags kept after tick");
	res_reconnect_a: assert property ($fell(st.gate) |-> st.res_on)
		else $error("resistor not reconnected at gate fall");
	burst_unarmed_a: assert property (soft_entry |-> unarmed_stretch)
		else $error("burst active before arming");
	latch_gate_a: assert property (st.ov || st.fault || st.mains || st.burst
		|=> !st.gate)
		else $error("gate high with a latch set");
endmodule

/* qr_gate_pkg.sv */
/*
 Types of the quasi-resonant gate control: bus carriers, comparator
 flags, drive outputs and operating modes.
 Assumes the constants header is included by the design files.
*/
package qr_gate_pkg;

	// AXI4-Lite master to slave
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} axi_req_s;

	// AXI4-Lite slave to master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_s;

	// Analog comparator results, high when the named condition holds
	typedef struct packed {
		logic zc_below_low;
		logic zc_below_restart;
		logic zc_above_1v;
		logic zc_above_primreg;
		logic zc_above_inter;
		logic sim_reached_fb;
		logic fb_below_lower;
		logic fb_above_upper;
		logic fb_above_jump;
		logic fb_below_burst;
		logic supply_above_on;
		logic supply_below_off;
		logic supply_below_off_burst;
		logic supply_above_ov;
		logic supply_below_ov_clear;
		logic fault_above;
		logic mains_low;
	} sense_s;

	// Outputs to the power stage
	typedef struct packed {
		logic gate;
		logic discharge_sink;
		logic charge_res_on;
		logic burst_threshold;
	} drive_s;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_STARTUP,
		MODE_SOFT,
		MODE_RUN
	} mode_e;

endpackage

/* quasi_resonant_gate_control_tb.sv */
/*
 Testbench of the quasi-resonant gate control: bus tasks and directed
 checks of switching, skip counter, restart, protection and burst.
 Assumes the design files and the flyback model are compiled first.
*/
`timescale 1ns/1ns
`include "qr_gate_cfg.svh"
module quasi_resonant_gate_control_tb;
	import qr_gate_pkg::*;
	localparam int STEP = 200; // Shortened skip step
	logic CLOCK;
	logic RST_B;
	axi_req_s req; // Master drive
	axi_rsp_s rsp; // Slave answer
	sense_s sen; // Comparators set here
	sense_s sense; // Comparators seen by the design
	drive_s drv; // Power stage drive
	logic [1:0] mode; // Flyback behaviour
	logic low;
	logic hi1v;
	logic simfb;
	int cyc; // Edge count
	int mismatches;
	int tests_run;
	int n; // Cycles waited
	int c0;
	logic [31:0] d;
	logic [1:0] r;
	logic [3:0] s;
	logic [3:0] s0;

	qr_gate_control #(.STEP_CYCLES(STEP)) u_qr_gate_control (.CLOCK(CLOCK), .RST_B(RST_B),
		.AXI_IN(req), .AXI_OUT(rsp), .SENSE(sense), .DRIVE(drv));
	flyback_model u_flyback_model (.clk(CLOCK), .gate(drv.gate), .mode(mode),
		.below_low(low), .above_1v(hi1v), .sim_fb(simfb));

	// Winding comparators come from the model
	always_comb begin
		sense = sen;
		sense.zc_below_low = low;
		sense.zc_below_restart = low;
		sense.zc_above_1v = hi1v;
		sense.sim_reached_fb = simfb;
	end

	initial begin
		CLOCK = 1'h0;
		forever #25 CLOCK = ~CLOCK;
	end

	always @(posedge CLOCK) cyc <= cyc + 1;

	// Count and report one compare
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Write; address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		bit aw;
		bit w;
		bit b;
		aw = 0;
		w = 0;
		b = 0;
		@(posedge CLOCK);
		req.awaddr <= a;
		req.awvalid <= 1'h1;
		req.wdata <= v;
		req.wstrb <= 4'hf;
		req.wvalid <= 1'h1;
		req.bready <= 1'h1;
		while (!b) begin
			@(posedge CLOCK);
			if (!aw && rsp.awready) begin
				aw = 1;
				req.awvalid <= 1'h0;
			end
			if (!w && rsp.wready) begin
				w = 1;
				req.wvalid <= 1'h0;
			end
			if (rsp.bvalid) begin
				b = 1;
				rs = rsp.bresp;
				req.bready <= 1'h0;
			end
		end
	endtask

	// Read one word
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		bit ar;
		bit t;
		ar = 0;
		t = 0;
		@(posedge CLOCK);
		req.araddr <= a;
		req.arvalid <= 1'h1;
		req.rready <= 1'h1;
		while (!t) begin
			@(posedge CLOCK);
			if (!ar && rsp.arready) begin
				ar = 1;
				req.arvalid <= 1'h0;
			end
			if (rsp.rvalid) begin
				t = 1;
				v = rsp.rdata;
				rs = rsp.rresp;
				req.rready <= 1'h0;
			end
		end
	endtask

	// Skip counter from the status word
	task automatic rsk(output logic [3:0] k);
		rd(`STATUS_OFS, d, r);
		k = d[`ST_SKIP_LSB +: 4];
	endtask

	// Wait for a gate level, at most lim cycles
	task automatic wg(input logic v, input int lim);
		n = 0;
		while (drv.gate !== v && n < lim) begin
			@(posedge CLOCK);
			n++;
		end
	endtask

	task automatic wait_to(input int t);
		while (cyc < t) @(posedge CLOCK);
	endtask

	// One off period: crossings before turn-on and its length
	task automatic period(input logic [3:0] k);
		int c;
		int t;
		logic p;
		wg(1'h1, 3000);
		wg(1'h0, 3000);
		c = 0;
		t = 0;
		p = low;
		while (drv.gate !== 1'h1 && t < 3000) begin
			@(posedge CLOCK);
			c += (low && !p);
			p = low;
			t++;
		end
		chk("crossings", k, c);
		chk("off_short", 1, t > `RING_SHORT_CYC && t < `RING_LONG_CYC);
	endtask

	task automatic note(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog on a hang
	initial begin
		repeat (40000) @(posedge CLOCK);
		mismatches++;
		$display("mismatch watchdog expected finish seen timeout");
		test_done;
	end

	initial begin
		RST_B = 1'h0;
		req = '0;
		sen = '0;
		mode = 2'h0;
		cyc = 0;
		mismatches = 0;
		tests_run = 0;
		repeat (20) @(posedge CLOCK);
		RST_B <= 1'h1;
		// Reset values and register map
		chk("gate_rst", 0, drv.gate);
		chk("res_rst", 1, drv.charge_res_on);
		rd(`CTRL_OFS, d, r);
		chk("ctrl_rst", 1, d);
		rd(`STATUS_OFS, d, r);
		chk("skip_rst", `SKIP_RESET, d[`ST_SKIP_LSB +: 4]);
		chk("mode_rst", 0, d[`ST_MODE_LSB +: 2]);
		rd(8'h08, d, r);
		chk("unmapped_rd", 0, d);
		chk("unmapped_rresp", `RESP_SLVERR, r);
		wr(8'h08, 32'h1, r);
		chk("unmapped_wr", `RESP_SLVERR, r);
		wr(`CTRL_OFS, 32'h0, r);
		rd(`CTRL_OFS, d, r);
		chk("ctrl_wr", 0, d);
		wr(`CTRL_OFS, 32'h1, r);
		wr(`STATUS_OFS, 32'h0, r);
		chk("status_wr", `RESP_OKAY, r);
		note("reset");
		// Start-up into soft start, then run
		sen.supply_above_on <= 1'h1;
		@(posedge CLOCK);
		sen.supply_above_on <= 1'h0;
		rd(`STATUS_OFS, d, r);
		chk("mode_soft", 1, d[`ST_MODE_LSB +: 2]);
		repeat (`BURST_ARM_CYC + 20) @(posedge CLOCK);
		rd(`STATUS_OFS, d, r);
		chk("mode_run", 2, d[`ST_MODE_LSB +: 2]);
		period(4'h1);
		note("start");
		// Low feedback steps the skip counter up
		sen.fb_below_lower <= 1'h1;
		c0 = cyc;
		rsk(s0);
		for (int i = 0; i < 3; i++) begin
			c0 += STEP;
			wait_to(c0);
			rsk(s);
			chk("skip_up", s0 + 4'h1, s);
			s0 = s;
		end
		sen.fb_below_lower <= 1'h0;
		repeat (2 * STEP) @(posedge CLOCK);
		c0 = cyc;
		rsk(s0);
		wait_to(c0 + 2 * STEP);
		rsk(s);
		chk("skip_hold", s0, s);
		period(s);
		// High feedback steps down, load jump sets one
		sen.fb_above_upper <= 1'h1;
		c0 = cyc;
		rsk(s0);
		wait_to(c0 + STEP);
		rsk(s);
		chk("skip_down", s0 - 4'h1, s);
		sen.fb_above_upper <= 1'h0;
		sen.fb_above_jump <= 1'h1;
		@(posedge CLOCK);
		sen.fb_above_jump <= 1'h0;
		rsk(s);
		chk("skip_jump", `SKIP_JUMP, s);
		note("skip");
		// Turn-off below one volt gives the long suppression
		mode <= 2'h3;
		wg(1'h1, 3000);
		wg(1'h0, 3000);
		wg(1'h1, 3000);
		chk("off_long", 1, n > `RING_LONG_CYC && n < 2 * `RESTART_CYC);
		mode <= 2'h0;
		// One short range pulse is acted on once
		repeat (2 * STEP) @(posedge CLOCK);
		c0 = cyc;
		sen.fb_below_lower <= 1'h1;
		@(posedge CLOCK);
		sen.fb_below_lower <= 1'h0;
		wait_to(c0 + 2 * STEP);
		rsk(s);
		chk("flag_once", 4'h2, s);
		wait_to(c0 + 3 * STEP);
		rsk(s);
		chk("flag_clear", 4'h2, s);
		note("range");
		// Damped winding: restart pulse; winding held high: none
		mode <= 2'h1;
		wg(1'h1, 3000);
		wg(1'h0, 3000);
		wg(1'h1, 3000);
		chk("restart", 1, n > `RESTART_CYC && n < `RESTART_CYC + 150);
		mode <= 2'h2;
		wg(1'h0, 3000);
		wg(1'h1, 2500);
		chk("no_restart", 2500, n);
		mode <= 2'h0;
		note("restart");
		// Discharge sink and charging resistor
		sen.zc_above_primreg <= 1'h1;
		repeat (2) @(posedge CLOCK);
		chk("sink_on", 1, drv.discharge_sink);
		sen.zc_above_primreg <= 1'h0;
		repeat (2) @(posedge CLOCK);
		chk("sink_off", 0, drv.discharge_sink);
		sen.zc_above_inter <= 1'h1;
		@(posedge CLOCK);
		sen.zc_above_inter <= 1'h0;
		n = 0;
		while (drv.charge_res_on !== 1'h0 && n < 3000) begin
			@(posedge CLOCK);
			n++;
		end
		chk("res_off", 0, drv.charge_res_on);
		wg(1'h1, 3000);
		wg(1'h0, 3000);
		chk("res_on", 1, drv.charge_res_on);
		note("regulation");
		// Overvoltage and fault latches
		for (int i = 0; i < 2; i++) begin
			if (i == 0)
				sen.supply_above_ov <= 1'h1;
			else
				sen.fault_above <= 1'h1;
			@(posedge CLOCK);
			sen.supply_above_ov <= 1'h0;
			sen.fault_above <= 1'h0;
			rd(`STATUS_OFS, d, r);
			chk("latch_set", 1, d[`ST_OV_BIT + i]);
			wg(1'h1, 1500);
			chk("latch_hold", 1500, n);
			sen.supply_below_ov_clear <= 1'h1;
			@(posedge CLOCK);
			sen.supply_below_ov_clear <= 1'h0;
			rd(`STATUS_OFS, d, r);
			chk("latch_clr", 0, d[`ST_OV_BIT + i]);
			wg(1'h1, 1500);
			chk("resume", 1, drv.gate);
		end
		// Mains undervoltage in the off time
		wg(1'h0, 3000);
		sen.mains_low <= 1'h1;
		@(posedge CLOCK);
		sen.mains_low <= 1'h0;
		wg(1'h1, 1500);
		chk("mains_hold", 1500, n);
		note("protection");
		// Burst, start-up and re-arm after soft start
		sen.fb_below_burst <= 1'h1;
		repeat (3) @(posedge CLOCK);
		chk("burst_thr", 2'h2, {drv.burst_threshold, drv.gate});
		sen.supply_below_off_burst <= 1'h1;
		@(posedge CLOCK);
		sen.supply_below_off_burst <= 1'h0;
		rd(`STATUS_OFS, d, r);
		chk("to_startup", 0, d[`ST_MODE_LSB +: 2]);
		c0 = cyc;
		sen.supply_above_on <= 1'h1;
		@(posedge CLOCK);
		sen.supply_above_on <= 1'h0;
		rd(`STATUS_OFS, d, r);
		chk("burst_left", 0, {d[`ST_BURST_BIT], drv.burst_threshold});
		// Raised turn-off level no longer applies once burst has ended
		sen.supply_below_off_burst <= 1'h1;
		@(posedge CLOCK);
		sen.supply_below_off_burst <= 1'h0;
		rd(`STATUS_OFS, d, r);
		chk("off_normal", 1, d[`ST_MODE_LSB +: 2]);
		wait_to(c0 + `BURST_ARM_CYC - 20);
		chk("burst_ignored", 0, drv.burst_threshold);
		wait_to(c0 + `BURST_ARM_CYC + 20);
		chk("burst_armed", 1, drv.burst_threshold);
		note("burst");
		test_done;
	end
endmodule
